// [hdl/peis_pkg.sv]
// shared constants and types of the event interrupt block
package peis_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] REG_CTRL_IDX = 8'h11;
  localparam logic [7:0] REG_ISR1_IDX = 8'h12;
  localparam logic [7:0] REG_FCC_IDX = 8'h14;
  localparam logic [7:0] REG_REC_IDX = 8'h15;
  // control register fields
  localparam int CTRL_INT_EN_BIT = 1;
  localparam int CTRL_INT_OE_BIT = 0;
  // status register layout: flags 13:8, enables 5:0
  localparam int ISR_FLAG_LSB = 8;
  localparam int ISR_EN_LSB = 0;
  localparam int NUM_EV = 6;
  localparam logic [NUM_EV-1:0] EV_EN_RESET = 6'h00;
  localparam logic [NUM_EV-1:0] FLAG_RESET = 6'h00;
  // counters
  localparam int FC_W = 8;
  localparam logic [7:0] FC_HALF = 8'h7F;
  localparam logic [7:0] FC_MAX = 8'hFF;
  localparam int RE_W = 16;
  localparam logic [15:0] RE_HALF = 16'h7FFF;
  localparam logic [15:0] RE_MAX = 16'hFFFF;

  typedef enum logic [1:0] {
    PEIS_IDLE = 2'b00,
    PEIS_ACCESS = 2'b01,
    PEIS_DONE = 2'b11
  } peis_bus_e;

  typedef struct packed {
    peis_bus_e state;
    logic write;
    logic sel;
    logic [7:0] idx;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } peis_bus_s;

  typedef struct packed {
    logic int_en;
    logic int_oe;
    logic [NUM_EV-1:0] ev_en;
    logic [NUM_EV-1:0] flag;
    logic pin_out;
    logic pin_oe_n;
    logic powerdown;
  } peis_top_s;
endpackage

// [hdl/peis_reg_if.sv]
// register access strobes between the bus slave and the core
`timescale 1ns/1ns
interface peis_reg_if;
  logic wr;
  logic rd;
  logic sel;
  logic [7:0] idx;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport slave (output wr, output rd, output sel, output idx, output wdata, input rdata);
  modport core (input wr, input rd, input sel, input idx, input wdata, output rdata);
endinterface

// [hdl/peis_sat_counter.sv]
// saturating event counter with clear on read and half-full crossing pulse
`timescale 1ns/1ns
module peis_sat_counter #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] HALF = 8'h7F,
  parameter logic [W-1:0] MAX = 8'hFF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // count control
  input wire logic inc,
  input wire logic clr,
  // state
  output logic [W-1:0] count,
  output logic half_evt
);
  typedef struct packed {
    logic [W-1:0] count;
    logic half_evt;
  } peis_cnt_s;
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  localparam logic [W-1:0] ZERO = '0;

  peis_cnt_s s;
  peis_cnt_s next_s;

  always_comb begin
    next_s = s;
    next_s.half_evt = 1'b0;
    if (clr) begin
      // an event during the clearing read still counts
      next_s.count = inc ? ONE : ZERO;
    end else if (inc && s.count != MAX) begin
      next_s.count = s.count + ONE; // R15 R16
      next_s.half_evt = (s.count == HALF); // R15 R16
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count = s.count;
  assign half_evt = s.half_evt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_cnt_saturate: assert property (count == MAX && inc && !clr |=> count == MAX) // R15 R16
    else $error("counter wrapped past maximum");
  chk_cnt_half_pulse: assert property (half_evt |-> count == HALF + ONE && $past(inc)) // R15 R16
    else $error("half-full pulse without crossing");
  chk_cnt_clear: assert property (clr && !inc |=> count == ZERO) // R15 R16
    else $error("counter not cleared on read");
endmodule // peis_sat_counter

// [hdl/peis_ahb_slave.sv]
// AHB-Lite slave turning transfers into register strobes
`timescale 1ns/1ns
module peis_ahb_slave import peis_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // register side
  peis_reg_if.slave bus
);
  peis_bus_s s;
  peis_bus_s next_s;
  logic take;

  // hsize is not decoded: only whole-word transfers are issued
  assign take = hsel && hready && htrans[1];

  always_comb begin
    next_s = s;
    next_s.hresp = 1'b0;
    case (s.state)
      PEIS_IDLE, PEIS_DONE: begin
        next_s.hreadyout = 1'b1;
        next_s.state = PEIS_IDLE;
        if (take) begin
          next_s.state = PEIS_ACCESS;
          next_s.write = hwrite;
          next_s.sel = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
          next_s.idx = haddr[9:2];
          next_s.hreadyout = 1'b0;
        end
      end
      PEIS_ACCESS: begin
        // one wait state keeps write data and read-clear in the same cycle
        next_s.state = PEIS_DONE;
        next_s.hreadyout = 1'b1;
        if (!s.write) begin
          next_s.hrdata = {16'h0000, bus.rdata};
        end
      end
      default: begin
        next_s.state = PEIS_IDLE;
        next_s.hreadyout = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= '{state: PEIS_IDLE, write: 1'b0, sel: 1'b0, idx: 8'h00,
             hrdata: 32'h00000000, hreadyout: 1'b1, hresp: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign bus.wr = (s.state == PEIS_ACCESS) && s.write;
  assign bus.rd = (s.state == PEIS_ACCESS) && !s.write;
  assign bus.sel = s.sel;
  assign bus.idx = s.idx;
  assign bus.wdata = hwdata[15:0];
  assign hreadyout = s.hreadyout;
  assign hrdata = s.hrdata;
  assign hresp = s.hresp;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_ahb_wait_state: assert property (take && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("data phase not exactly one wait state");
endmodule // peis_ahb_slave

// [hdl/peis_top.sv]
// event interrupt status logic with control, status and counter registers
// Operation
// R1 - control bit 1 globally allows event interrupts and resets to 0.
// R2 - control bit 0 makes the shared pin an interrupt output when 1, a power-down input when 0.
// R3 - as an output the shared pin shows a pending interrupt by going low.
// R4 - an interrupt needs the global enable, the output enable and the event's own enable.
// R5 - a status flag is 1 when its event happened since the last status read.
// R6 - an event whose enable is set raises the interrupt.
// R7 - flags latch events whatever the enables say.
// R8 - flag bit 13 records a link change, cleared on read, enabled by bit 5.
// R9 - flag bit 12 records a speed change, cleared on read, enabled by bit 4.
// R10 - flag bit 11 records a duplex change, cleared on read, enabled by bit 3.
// R11 - flag bit 10 records auto-negotiation completion, cleared on read, enabled by bit 2.
// R12 - flag bit 9 records the false-carrier counter passing half, enabled by bit 1.
// R13 - flag bit 8 records the receive-error counter passing half, enabled by bit 0.
// R14 - status bits 15:14 and 7:6 ignore writes and read as zero.
// R15 - the 8-bit false-carrier counter saturates, signals passing 7Fh, clears on read.
// R16 - the 16-bit receive-error counter saturates, signals passing 7FFFh, clears on read.
// R17 - the pin stays asserted while an enabled flag is pending and idles once none is.
`timescale 1ns/1ns
module peis_top import peis_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // AHB-Lite register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // phy events, one-cycle pulses
  input wire logic link_change,
  input wire logic speed_change,
  input wire logic duplex_change,
  input wire logic an_complete,
  input wire logic false_carrier_event,
  input wire logic rx_error_event,
  // shared interrupt / power-down pin
  input wire logic irq_or_powerdown_pin_in,
  output logic irq_or_powerdown_pin_out,
  output logic irq_or_powerdown_pin_oe_n,
  output logic powerdown
);
  peis_reg_if rif ();

  peis_top_s s;
  peis_top_s next_s;
  logic [FC_W-1:0] fc_count;
  logic [RE_W-1:0] re_count;
  logic fc_half;
  logic re_half;
  logic fc_clr;
  logic re_clr;
  logic isr_rd;
  logic isr_wr;
  logic ctrl_wr;
  logic [NUM_EV-1:0] ev;
  logic irq_now;
  logic [15:0] rdata;
  logic [NUM_EV-1:0] flag_next;

  peis_ahb_slave u_bus (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .bus(rif.slave)
  );

  assign fc_clr = rif.rd && rif.sel && rif.idx == REG_FCC_IDX;
  assign re_clr = rif.rd && rif.sel && rif.idx == REG_REC_IDX;
  assign isr_rd = rif.rd && rif.sel && rif.idx == REG_ISR1_IDX;
  assign isr_wr = rif.wr && rif.sel && rif.idx == REG_ISR1_IDX;
  assign ctrl_wr = rif.wr && rif.sel && rif.idx == REG_CTRL_IDX;

  peis_sat_counter #(
    .W(FC_W),
    .HALF(FC_HALF),
    .MAX(FC_MAX)
  ) u_fc (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .inc(false_carrier_event),
    .clr(fc_clr),
    .count(fc_count),
    .half_evt(fc_half)
  ); // R15

  peis_sat_counter #(
    .W(RE_W),
    .HALF(RE_HALF),
    .MAX(RE_MAX)
  ) u_re (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .inc(rx_error_event),
    .clr(re_clr),
    .count(re_count),
    .half_evt(re_half)
  ); // R16

  // order matches flag bits 13 down to 8
  assign ev = {link_change, speed_change, duplex_change, an_complete, fc_half, re_half};

  // read view; unmapped words and reserved bits read as zero
  always_comb begin
    rdata = 16'h0000;
    if (rif.sel) begin
      case (rif.idx)
        REG_CTRL_IDX: begin
          rdata[CTRL_INT_EN_BIT] = s.int_en;
          rdata[CTRL_INT_OE_BIT] = s.int_oe;
        end
        REG_ISR1_IDX: begin
          rdata[ISR_FLAG_LSB +: NUM_EV] = s.flag; // R8 R9 R10 R11 R12 R13 R14
          rdata[ISR_EN_LSB +: NUM_EV] = s.ev_en;
        end
        REG_FCC_IDX: rdata = {8'h00, fc_count};
        REG_REC_IDX: rdata = re_count;
        default: rdata = 16'h0000;
      endcase
    end
  end
  assign rif.rdata = rdata;

  // one flag per event; a new event beats the clearing read so it is never lost
  for (genvar i = 0; i < NUM_EV; i++) begin : g_flag
    assign flag_next[i] = ev[i] || (s.flag[i] && !isr_rd); // R5 R7
  end

  assign irq_now = s.int_en && s.int_oe && |(s.flag & s.ev_en); // R1 R4 R6 R17

  always_comb begin
    next_s = s;
    if (ctrl_wr) begin
      next_s.int_en = rif.wdata[CTRL_INT_EN_BIT]; // R1
      next_s.int_oe = rif.wdata[CTRL_INT_OE_BIT]; // R2
    end
    if (isr_wr) begin
      // flag and reserved bits are read-only
      next_s.ev_en = rif.wdata[ISR_EN_LSB +: NUM_EV]; // R14
    end
    next_s.flag = flag_next; // R5 R7 R8 R9 R10 R11 R12 R13
    next_s.pin_out = !irq_now; // R3 R17
    next_s.pin_oe_n = !s.int_oe; // R2
    // pin is active low; only sampled while it is an input
    next_s.powerdown = !s.int_oe && !irq_or_powerdown_pin_in; // R2
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= '{int_en: 1'b0, int_oe: 1'b0, ev_en: EV_EN_RESET, flag: FLAG_RESET,
             pin_out: 1'b1, pin_oe_n: 1'b1, powerdown: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign irq_or_powerdown_pin_out = s.pin_out;
  assign irq_or_powerdown_pin_oe_n = s.pin_oe_n;
  assign powerdown = s.powerdown;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_global_enable_off: assert property (!s.int_en |=> irq_or_powerdown_pin_out) // R1
    else $error("interrupt driven while globally disabled");

  chk_pin_direction: assert property ($changed(s.int_oe) |=> // R2
    irq_or_powerdown_pin_oe_n == !$past(s.int_oe))
    else $error("pin direction does not follow output enable");

  chk_powerdown_input: assert property (s.int_oe |=> !powerdown) // R2
    else $error("power-down taken while pin is an output");

  chk_irq_active_low: assert property (irq_now |=> !irq_or_powerdown_pin_out) // R3 R6
    else $error("pending enabled event not shown low on pin");

  chk_irq_three_gates: assert property (!irq_or_powerdown_pin_out |-> // R4
    $past(s.int_en && s.int_oe && |(s.flag & s.ev_en)))
    else $error("pin low without all enables set");

  chk_event_latched: assert property (link_change |=> s.flag[5]) // R5 R7 R8
    else $error("link change not latched");

  chk_event_to_pin: assert property (speed_change && s.int_en && s.int_oe && // R6 R9
    s.ev_en[4] && !ctrl_wr && !isr_wr |=> ##1 !irq_or_powerdown_pin_out)
    else $error("enabled speed change gave no interrupt");

  chk_flag_clear_read: assert property (isr_rd && ev == 6'h00 |=> s.flag == 6'h00) // R10 R11
    else $error("status read did not clear flags");

  chk_read_race: assert property (isr_rd && duplex_change |=> s.flag[3]) // R10
    else $error("event lost in clearing read");

  chk_counter_flags: assert property (fc_half |=> s.flag[1]) // R12 R15
    else $error("false-carrier half event not flagged");

  chk_rxerr_flag: assert property (re_half |=> s.flag[0]) // R13 R16
    else $error("receive-error half event not flagged");

  chk_status_write_only_en: assert property (isr_wr && ev == 6'h00 && !isr_rd |=> s.flag == $past(s.flag)) // R14
    else $error("write altered read-only flags");

  chk_pin_release: assert property (isr_rd && ev == 6'h00 |=> ##1 irq_or_powerdown_pin_out) // R17
    else $error("pin stayed low after clearing read");

  // pin direction and power-down input
  chk_pin_oe_follows: assert property ( // R2
    s.int_oe |=> !irq_or_powerdown_pin_oe_n
  ) else $error("pin not driven while output enabled");

  chk_pin_input_idle: assert property ( // R2 R4
    !s.int_oe |=> irq_or_powerdown_pin_oe_n && irq_or_powerdown_pin_out
  ) else $error("pin driven or asserted while it is an input");

  chk_pin_low_driven: assert property ( // R3
    !irq_or_powerdown_pin_out |-> !irq_or_powerdown_pin_oe_n
  ) else $error("interrupt level shown while pin not driven");

  chk_powerdown_request: assert property ( // R2
    !s.int_oe && !irq_or_powerdown_pin_in |=> powerdown
  ) else $error("low pin input gave no power-down");

  chk_powerdown_idle: assert property ( // R2
    irq_or_powerdown_pin_in |=> !powerdown
  ) else $error("power-down without a low pin");

  // control and enable registers
  chk_ctrl_write_en: assert property ( // R1
    ctrl_wr |=> s.int_en == $past(rif.wdata[CTRL_INT_EN_BIT])
  ) else $error("global enable not written");

  chk_ctrl_write_oe: assert property ( // R2
    ctrl_wr |=> s.int_oe == $past(rif.wdata[CTRL_INT_OE_BIT])
  ) else $error("output enable not written");

  chk_ctrl_holds: assert property ( // R1 R2
    !ctrl_wr |=> $stable(s.int_en) && $stable(s.int_oe)
  ) else $error("control bits changed without a write");

  chk_enable_write: assert property ( // R8 R9 R10 R11 R12 R13
    isr_wr |=> s.ev_en == $past(rif.wdata[ISR_EN_LSB +: NUM_EV])
  ) else $error("event enables not written");

  chk_enable_holds: assert property ( // R8 R9 R10 R11 R12 R13
    !isr_wr |=> $stable(s.ev_en)
  ) else $error("event enables changed without a write");

  // read data as the bus sees it
  chk_status_read_view: assert property ( // R8 R9 R10 R11 R12 R13 R14
    isr_rd |=> hrdata == {16'h0000, 2'b00, $past(s.flag), 2'b00, $past(s.ev_en)}
  ) else $error("status read returned wrong layout");

  chk_ctrl_read_view: assert property ( // R1 R2
    rif.rd && rif.sel && rif.idx == REG_CTRL_IDX |=>
    hrdata == {30'h00000000, $past(s.int_en), $past(s.int_oe)}
  ) else $error("control read returned wrong layout");

  chk_fc_read_view: assert property ( // R15
    fc_clr |=> hrdata == {24'h000000, $past(fc_count)}
  ) else $error("false-carrier count read wrong");

  chk_re_read_view: assert property ( // R16
    re_clr |=> hrdata == {16'h0000, $past(re_count)}
  ) else $error("receive-error count read wrong");

  // counters
  chk_fc_cleared: assert property ( // R15
    fc_clr && !false_carrier_event |=> fc_count == 8'h00
  ) else $error("false-carrier count not cleared by read");

  chk_fc_clr_with_event: assert property ( // R15
    fc_clr && false_carrier_event |=> fc_count == 8'h01
  ) else $error("event during false-carrier read lost");

  chk_re_cleared: assert property ( // R16
    re_clr && !rx_error_event |=> re_count == 16'h0000
  ) else $error("receive-error count not cleared by read");

  chk_re_clr_with_event: assert property ( // R16
    re_clr && rx_error_event |=> re_count == 16'h0001
  ) else $error("event during receive-error read lost");

  chk_fc_stuck: assert property ( // R15
    fc_count == FC_MAX && !fc_clr |=> fc_count == FC_MAX
  ) else $error("false-carrier count left its maximum");

  chk_re_stuck: assert property ( // R16
    re_count == RE_MAX && !re_clr |=> re_count == RE_MAX
  ) else $error("receive-error count left its maximum");

  chk_fc_counts: assert property ( // R15
    false_carrier_event && !fc_clr && fc_count != FC_MAX |=> fc_count == $past(fc_count) + 8'h01
  ) else $error("false-carrier event not counted");

  chk_re_counts: assert property ( // R16
    rx_error_event && !re_clr && re_count != RE_MAX |=> re_count == $past(re_count) + 16'h0001
  ) else $error("receive-error event not counted");

  chk_fc_half_once: assert property ( // R15
    fc_half |=> !fc_half
  ) else $error("false-carrier half event longer than one cycle");

  chk_re_half_once: assert property ( // R16
    re_half |=> !re_half
  ) else $error("receive-error half event longer than one cycle");

  // interrupt level
  chk_irq_held: assert property ( // R17
    irq_now && !isr_rd && !ctrl_wr && !isr_wr |=> irq_now
  ) else $error("interrupt dropped while still pending");

  chk_irq_no_flag: assert property ( // R4 R17
    s.flag == 6'h00 |=> irq_or_powerdown_pin_out
  ) else $error("pin low with nothing pending");

  chk_irq_masked: assert property ( // R6
    s.ev_en == 6'h00 |=> irq_or_powerdown_pin_out
  ) else $error("pin low with every event masked");

  // every event, gated or not, lands in its flag and stays until read
  for (genvar i = 0; i < NUM_EV; i++) begin : g_ev_chk
    chk_flag_sets: assert property ( // R5 R7
      @(posedge ref_clk) disable iff (sys_rst) ev[i] |=> s.flag[i]
    ) else $error("event not latched in its flag");

    chk_flag_holds: assert property ( // R5
      @(posedge ref_clk) disable iff (sys_rst) s.flag[i] && !isr_rd |=> s.flag[i]
    ) else $error("flag dropped without a status read");

    chk_flag_no_spurious: assert property ( // R5
      @(posedge ref_clk) disable iff (sys_rst) !s.flag[i] && !ev[i] |=> !s.flag[i]
    ) else $error("flag set without its event");
  end

  cov_event_irq: cover property (an_complete ##2 !irq_or_powerdown_pin_out ##[1:50] isr_rd);
  cov_read_race: cover property (isr_rd && |ev);
  cov_fc_half: cover property (fc_half);
  cov_powerdown: cover property (powerdown);
  cov_fc_saturated: cover property (fc_count == FC_MAX);
endmodule // peis_top

// [sim/peis_pin_model.sv]
// host-side model of the shared interrupt / power-down pin
`timescale 1ns/1ns
module peis_pin_model (
  // design side of the pin
  input wire logic pin_out,
  input wire logic pin_oe_n,
  // host asks for power-down by pulling low
  input wire logic pd_req,
  // resolved pin level
  output logic pin_level
);
  // pull-up holds the line high when nobody drives it
  assign pin_level = !pin_oe_n ? pin_out : !pd_req;
endmodule // peis_pin_model

// [sim/phy_event_interrupt_status_tb.sv]
// self-checking testbench of the event interrupt block
`timescale 1ns/1ns
module phy_event_interrupt_status_tb import peis_pkg::*;;
  localparam logic [31:0] A_CTRL = {22'h0, REG_CTRL_IDX, 2'b00};
  localparam logic [31:0] A_ISR = {22'h0, REG_ISR1_IDX, 2'b00};
  localparam logic [31:0] A_FC = {22'h0, REG_FCC_IDX, 2'b00};
  localparam logic [31:0] A_RE = {22'h0, REG_REC_IDX, 2'b00};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pin_out;
  logic pin_oe_n;
  logic powerdown;
  logic pin_level;
  logic pd_req = 1'b0;
  logic [5:0] ev = 6'h00;
  int mismatches = 0;
  int cmp_count = 0;

  always #50 ref_clk = ~ref_clk;

  peis_top i_peis_top (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .link_change(ev[5]), .speed_change(ev[4]), .duplex_change(ev[3]),
    .an_complete(ev[2]), .false_carrier_event(ev[1]), .rx_error_event(ev[0]),
    .irq_or_powerdown_pin_in(pin_level), .irq_or_powerdown_pin_out(pin_out),
    .irq_or_powerdown_pin_oe_n(pin_oe_n), .powerdown(powerdown)
  );

  peis_pin_model i_peis_pin_model (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pd_req(pd_req), .pin_level(pin_level)
  );

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // hready is sampled just after each edge, before that edge's updates land
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    r = hrdata;
    cmp("hresp", 32'h0, hresp);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    cmp(name, exp, r);
  endtask

  // outputs read just after an edge still show what stood at it
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic ev_run(input int i, input int n);
    ev[i] <= 1'b1;
    repeat (n) @(posedge ref_clk);
    ev[i] <= 1'b0;
    settle(3);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rdc("ctrl", A_CTRL, 32'h0);
    rdc("status", A_ISR, 32'h0);
    cmp("oe_n", 32'h1, pin_oe_n);
    pd_req <= 1'b1;
    settle(3);
    cmp("powerdown", 32'h1, powerdown);
    pd_req <= 1'b0;
    settle(3);
    cmp("powerdown", 32'h0, powerdown);
    wr(32'h60, 32'hFFFF);
    rdc("unmapped", 32'h60, 32'h0);
    // events latch although every gate is shut
    for (int i = 2; i < 6; i++) begin
      ev_run(i, 1);
      cmp("pin", 32'h1, pin_level);
      rdc("flag", A_ISR, 32'h1 << (ISR_FLAG_LSB + i));
      rdc("cleared", A_ISR, 32'h0);
    end
    wr(A_ISR, 32'hFFFF);
    rdc("status", A_ISR, 32'h3F);
    wr(A_CTRL, 32'hFFFF);
    rdc("ctrl", A_CTRL, 32'h3);
    // pin asserts only with both control bits set
    for (int i = 0; i < 4; i++) begin
      wr(A_CTRL, i);
      ev_run(5, 1);
      cmp("pin", (i == 3) ? 32'h0 : 32'h1, pin_level);
      cmp("oe_n", !i[0], pin_oe_n);
      rdc("status", A_ISR, 32'h203F);
      settle(2);
      cmp("pin idle", 32'h1, pin_level);
    end
    wr(A_ISR, 32'h1F);
    ev_run(5, 1);
    cmp("pin", 32'h1, pin_level);
    rdc("status", A_ISR, 32'h201F);
    ev_run(4, 1);
    cmp("pin", 32'h0, pin_level);
    rdc("status", A_ISR, 32'h101F);
    ev_run(3, 1);
    ev_run(2, 1);
    rdc("status", A_ISR, 32'h0C1F);
    ev[3] <= 1'b1;
    rdc("race", A_ISR, 32'h081F);
    ev[3] <= 1'b0;
    rdc("race kept", A_ISR, 32'h081F);
    ev_run(1, 127);
    rdc("status", A_ISR, 32'h1F);
    ev_run(1, 1);
    cmp("pin", 32'h0, pin_level);
    rdc("status", A_ISR, 32'h021F);
    rdc("fc count", A_FC, 32'h80);
    rdc("fc count", A_FC, 32'h0);
    ev_run(1, 300);
    rdc("fc count", A_FC, 32'hFF);
    rdc("status", A_ISR, 32'h021F);
    ev_run(0, 32767);
    rdc("status", A_ISR, 32'h1F);
    ev_run(0, 1);
    rdc("status", A_ISR, 32'h011F);
    ev_run(0, 32800);
    rdc("re count", A_RE, 32'hFFFF);
    rdc("re count", A_RE, 32'h0);
    tally_and_finish();
  end
endmodule // phy_event_interrupt_status_tb
